// >>> tb/mbscs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module mbscs_asserts
#(
    parameter int unsigned MFI_W = 8
)
(
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // link
    input wire logic rx_frame_end,
    input wire logic tx_busy,
    input wire logic rts,
    input wire logic reply_start,
    input wire logic cmd_valid,
    input wire logic cmd_broadcast,
    // drive side
    input wire logic [MFI_W-1:0] mfi_term,
    input wire logic [MFI_W-1:0] mfi_eff,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic comm_fault,
    input wire logic stop_ramp,
    input wire logic stop_coast,
    input wire logic stop_fast
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag outside access");
    rts_busy_a: assert property (tx_busy |=> rts)
        else $error("rts low while sending");
    cmd_cause_a: assert property (cmd_valid |-> $past(rx_frame_end))
        else $error("command without frame end");
    bcast_quiet_a: assert property (cmd_valid && cmd_broadcast |=> !reply_start [*3])
        else $error("reply to broadcast");
    stop_cause_a: assert property ((stop_ramp || stop_coast || stop_fast) |->
        $past(comm_fault) && $onehot0({stop_ramp, stop_coast, stop_fast})) else $error("bad stop action");
    run_excl_a: assert property (!(run_fwd && run_rev))
        else $error("both directions");
    mfi_or_a: assert property ($past(presetn) |-> ($past(mfi_term) & ~mfi_eff) == '0)
        else $error("terminal input lost");
    cover property (cmd_valid && cmd_broadcast);
    cover property (reply_start);
    cover property (stop_fast);
endmodule
bind mbscs_top mbscs_asserts #(.MFI_W(MFI_W)) mbscs_asserts_i (.*);
`default_nettype wire

// >>> tb/mbscs_master.sv
`timescale 1ns/10ps
`default_nettype none
module mbscs_master
    import mbscs_pkg::*;
(
    // clock
    input wire logic pclk,
    // byte stream into the block
    output logic rx_valid = 1'b0,
    output logic [7:0] rx_data = 8'h00,
    output logic rx_frame_end = 1'b0,
    // transmitter
    input wire logic reply_start,
    output logic tx_busy
);
    int k = 0;
    // transmitter stays busy a short burst after each reply start
    always @(posedge pclk) k <= reply_start ? 8 : (k > 0 ? k - 1 : 0);
    assign tx_busy = (k != 0);
    // one read request; bad flips a check bit to spoil the frame
    task automatic send(input logic [7:0] a, input logic bad);
        logic [7:0] f[6];
        logic [15:0] c;
        f = '{a, 8'h03, 8'h00, 8'h25, 8'h00, 8'h00};
        c = CRC_INIT;
        for (int i = 0; i < 4; i++)
        begin
            c = c ^ f[i];
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        f[4] = c[7:0] ^ {7'h0, bad};
        f[5] = c[15:8];
        for (int i = 0; i < 6; i++)
        begin
            @(posedge pclk) rx_valid <= 1'b1;
            rx_data <= f[i];
            // released data line shows the inverse, not a stale byte
            @(posedge pclk) rx_valid <= 1'b0;
            rx_data <= ~f[i];
        end
        @(posedge pclk) rx_frame_end <= 1'b1;
        @(posedge pclk) rx_frame_end <= 1'b0;
        repeat (40) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/mbscs_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mbscs_top_bench;
    import mbscs_pkg::*;
    localparam int MS = 10;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, power_restart = 0, ext_ref_sel = 0;
    logic pready, pslverr, rx_valid, rx_frame_end, tx_busy, reply_start, rts, cmd_valid, cmd_broadcast;
    logic run_fwd, run_rev, comm_fault, stop_ramp, stop_coast, stop_fast, slv;
    logic [7:0] paddr = 0, rx_data, mfi_term = 0, mfi_eff;
    logic [31:0] pwdata = 0, prdata, q, lk;
    logic [16:0] baud_div, pb;
    logic [15:0] volt_raw = 0, freq_ref, param_value;
    logic [1:0] parity_mode;
    int n_mismatch = 0, checks_done = 0, seed = 29, cyc = 0, t0 = 0, lat = 0, n_cmd = 0, n_bc = 0, n_rep = 0;
    always #5 pclk = ~pclk;
    mbscs_top #(.MS_CYC(MS), .TICK_CYC(20)) mbscs_top_i (.*);
    mbscs_master mbscs_master_i (.*);
    // pulse counters and reply latency in cycles
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        n_cmd <= n_cmd + cmd_valid;
        n_bc <= n_bc + cmd_broadcast;
        n_rep <= n_rep + reply_start;
        if (cmd_valid) t0 <= cyc;
        if (reply_start) lat <= cyc - t0;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        n = 0;
        do @(posedge pclk) n++; while (pready !== 1'b1 && n < 20);
        q = prdata;
        slv = pslverr;
        chk("pready", pready, 1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rs();
        power_restart <= 1;
        @(posedge pclk) power_restart <= 0;
        repeat (3) @(posedge pclk);
    endtask
    function automatic logic [16:0] baud(input int c);
        int t[9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
        return 17'(CLK_HZ / t[c]);
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard, far beyond the fewer than a thousand cycles the run needs
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, OFS_STATUS, 0);
        chk("status", q & 32'h00ff3f00, {8'h0, NODE_ADDR_RST, 4'h0, BIT_RATE_RST, 8'h0});
        chk("baud", baud_div, baud(3));
        chk("rts idle", rts, 0);
        apb(0, 8'h4c, 0);
        chk("unmapped", {q[30:0], slv}, 1);
        apb(1, OFS_NODE_ADDR, 32'h21);
        apb(0, OFS_NODE_ADDR, 0);
        chk("addr range", q, NODE_ADDR_RST);
        pb = baud(3);
        // parity codes above 2 are refused, so odd parity stays
        for (int c = 0; c < 9; c++)
        begin
            apb(1, OFS_BIT_RATE, c);
            apb(1, OFS_PARITY, c);
            chk("baud held", baud_div, pb);
            rs();
            pb = baud(c);
            chk("baud", baud_div, pb);
            chk("parity", parity_mode, c > 2 ? 2 : c);
        end
        mbscs_master_i.send(NODE_ADDR_RST, 0);
        chk("reply gap", lat, 2);
        mbscs_master_i.send(8'h00, 0);
        mbscs_master_i.send(NODE_ADDR_RST, 1);
        mbscs_master_i.send(8'h05, 0);
        chk("frames", {n_bc[3:0], n_cmd[3:0], n_rep[3:0]}, 12'h121);
        apb(1, OFS_REPLY_DELAY, 3);
        mbscs_master_i.send(NODE_ADDR_RST, 0);
        chk("reply delay", lat, 2 + 3 * MS);
        apb(1, OFS_NODE_ADDR, 0);
        rs();
        mbscs_master_i.send(8'h00, 0);
        chk("silent", {n_cmd[3:0], n_rep[3:0]}, 8'h42);
        apb(1, OFS_SOURCES, 32'h0a);
        for (int i = 0; i < 10; i++)
        begin
            lk = (i < 2) ? 32'h3 + 32'(i) * 4 : $random(seed);
            apb(1, OFS_RUN_METHOD, lk[2]);
            apb(1, OFS_RUN_CMD, lk[1:0]);
            @(posedge pclk);
            chk("run", {run_rev, run_fwd}, lk[2] ? {lk[0] & lk[1], lk[0] & !lk[1]} :
                {lk[1] & !lk[0], lk[0] & !lk[1]});
        end
        apb(1, OFS_FREQ_REF, lk);
        @(posedge pclk);
        chk("freq", freq_ref, lk[15:0]);
        ext_ref_sel <= 1;
        volt_raw <= lk[31:16];
        repeat (2) @(posedge pclk);
        chk("no link", {run_rev, run_fwd, freq_ref}, 0);
        for (int u = 0; u < 2; u++)
        begin
            apb(1, OFS_VMON_UNIT, u);
            apb(0, OFS_VMON, 0);
            chk("vmon", q, u ? volt_raw / 10 : volt_raw);
        end
        apb(1, OFS_PARAM, 32'haa);
        chk("param now", param_value, 16'haa);
        apb(1, OFS_APPLY_SEL, 0);
        apb(1, OFS_PARAM, lk);
        chk("param held", param_value, 16'haa);
        apb(1, OFS_APPLY, 1);
        chk("param applied", param_value, lk[15:0]);
        mfi_term <= lk[7:0];
        apb(1, OFS_MFI_LINK, lk[15:8]);
        @(posedge pclk);
        chk("mfi", mfi_eff, lk[7:0] | lk[15:8]);
        apb(1, OFS_LOSS_TIME, 101);
        apb(0, OFS_LOSS_TIME, 0);
        chk("loss time", q, LOSS_TIME_RST);
        apb(1, OFS_LOSS_TIME, 0);
        // last pass disables detection; a cleared fault must then stay clear
        for (int a = 0; a < 4; a++)
        begin
            apb(1, OFS_LOSS_CFG, a < 3 ? 16 + a : 3);
            apb(1, OFS_FAULT_CTRL, 1);
            repeat (60) @(posedge pclk);
            chk("loss", {stop_fast, stop_coast, stop_ramp, comm_fault}, a < 3 ? (2 << a) | 1 : 0);
        end
        // rts held on, as suits two-wire wiring
        apb(1, OFS_TX_CTRL, 0);
        @(posedge pclk);
        chk("rts on", rts, 1);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verilog/mbscs_pkg.sv
`default_nettype none
package mbscs_pkg;
    // clock and time bases
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_TIME_NS = 1_000_000;
    localparam int unsigned MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOSS_TICK_MS = 100;
    localparam int unsigned LOSS_TICK_CYCLES = LOSS_TICK_MS * MS_CYCLES;

    // register byte offsets
    localparam logic [7:0] OFS_NODE_ADDR = 8'h00;
    localparam logic [7:0] OFS_BIT_RATE = 8'h04;
    localparam logic [7:0] OFS_PARITY = 8'h08;
    localparam logic [7:0] OFS_LOSS_CFG = 8'h0c;
    localparam logic [7:0] OFS_REPLY_DELAY = 8'h10;
    localparam logic [7:0] OFS_TX_CTRL = 8'h14;
    localparam logic [7:0] OFS_LOSS_TIME = 8'h18;
    localparam logic [7:0] OFS_VMON_UNIT = 8'h1c;
    localparam logic [7:0] OFS_APPLY_SEL = 8'h20;
    localparam logic [7:0] OFS_RUN_METHOD = 8'h24;
    localparam logic [7:0] OFS_SOURCES = 8'h28;
    localparam logic [7:0] OFS_RUN_CMD = 8'h2c;
    localparam logic [7:0] OFS_FREQ_REF = 8'h30;
    localparam logic [7:0] OFS_MFI_LINK = 8'h34;
    localparam logic [7:0] OFS_PARAM = 8'h38;
    localparam logic [7:0] OFS_APPLY = 8'h3c;
    localparam logic [7:0] OFS_FAULT_CTRL = 8'h40;
    localparam logic [7:0] OFS_STATUS = 8'h44;
    localparam logic [7:0] OFS_VMON = 8'h48;

    // setting limits and reset values
    localparam logic [7:0] NODE_ADDR_MAX = 8'h20;
    localparam logic [7:0] NODE_ADDR_RST = 8'h1f;
    localparam logic [3:0] BIT_RATE_MAX = 4'h8;
    localparam logic [3:0] BIT_RATE_RST = 4'h3;
    localparam logic [1:0] PARITY_MAX = 2'h2;
    localparam logic [1:0] PARITY_RST = 2'h0;
    localparam logic [1:0] STOP_ACT_RST = 2'h3;
    localparam logic LOSS_EN_RST = 1'b1;
    localparam logic [6:0] LOSS_TIME_MAX = 7'h64;
    localparam logic [6:0] LOSS_TIME_RST = 7'h14;
    localparam logic TX_CTRL_RST = 1'b1;
    localparam logic VMON_UNIT_RST = 1'b0;
    localparam logic APPLY_SEL_RST = 1'b1;
    localparam logic RUN_METHOD_RST = 1'b0;
    localparam logic [1:0] SRC_SERIAL = 2'h2;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    // loss stop actions
    typedef enum logic [1:0] {MBSCS_STOP_RAMP, MBSCS_STOP_COAST, MBSCS_STOP_FAST, MBSCS_ALARM_ONLY} mbscs_stop_t;
endpackage
`default_nettype wire

// >>> verilog/mbscs_top.sv
`timescale 1ns/10ps
`default_nettype none
module mbscs_top
    import mbscs_pkg::*;
#(
    parameter int unsigned MS_CYC = MS_CYCLES,
    parameter int unsigned TICK_CYC = LOSS_TICK_CYCLES,
    parameter int unsigned MFI_W = 8
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power restart strobe
    input wire logic power_restart,
    // received byte stream from the framer
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_end,
    // transmitter handshake
    input wire logic tx_busy,
    output logic reply_start,
    output logic rts,
    output logic [16:0] baud_div,
    output logic [1:0] parity_mode,
    // accepted command
    output logic cmd_valid,
    output logic cmd_broadcast,
    // drive side
    input wire logic ext_ref_sel,
    input wire logic [15:0] volt_raw,
    input wire logic [MFI_W-1:0] mfi_term,
    output logic [MFI_W-1:0] mfi_eff,
    output logic run_fwd,
    output logic run_rev,
    output logic [15:0] freq_ref,
    output logic [15:0] param_value,
    output logic comm_fault,
    output logic stop_ramp,
    output logic stop_coast,
    output logic stop_fast
);

    // one modbus crc step over a byte, lsb first
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        c = crc ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // bit period in clocks for a rate code
    function automatic logic [16:0] rate_div(input logic [3:0] code);
        int unsigned bps;
        bps = 9600;
        unique case (code)
            4'h0: bps = 1200;
            4'h1: bps = 2400;
            4'h2: bps = 4800;
            4'h3: bps = 9600;
            4'h4: bps = 19200;
            4'h5: bps = 38400;
            4'h6: bps = 57600;
            4'h7: bps = 76800;
            4'h8: bps = 115200;
            default: bps = 9600;
        endcase
        return 17'(CLK_HZ / bps);
    endfunction

    // stored settings
    logic [7:0] node_address_setting_r;
    logic [3:0] bit_rate_select_r;
    logic [1:0] parity_select_r;
    logic [1:0] loss_stop_action_r;
    logic loss_detect_enable_r;
    logic [7:0] reply_delay_time_r;
    logic tx_enable_control_r;
    logic [6:0] loss_detect_time_r;
    logic voltage_monitor_unit_r;
    logic apply_command_select_r;
    logic run_method_select_r;
    logic [7:0] sources_r;
    logic [1:0] run_cmd_r;
    logic [15:0] freq_link_r;
    logic [MFI_W-1:0] mfi_link_r;
    logic [15:0] param_stage_r;
    // live serial settings
    logic [7:0] node_act_r;
    logic [3:0] rate_act_r;
    logic [1:0] parity_act_r;
    // link supervision state
    logic [15:0] crc_r;
    logic [7:0] frame_addr_r;
    logic first_r;
    logic [7:0] byte_cnt_r;
    logic reply_pend_r;
    logic [7:0] delay_ms_r;
    logic [31:0] delay_cyc_r;
    logic [31:0] tick_cyc_r;
    logic [6:0] tick_cnt_r;
    logic [15:0] vmon_r;

    logic wr_en;
    logic rd_setup;
    logic map_hit;
    logic fault_clr;
    logic apply_cmd;
    logic loss_trip;
    logic [1:0] freq_src;
    logic [1:0] run_src;
    logic link_ok;
    logic [31:0] rd_mux;

    // a write lands at the access edge, when our pready is high
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_setup = psel & ~penable;
    assign fault_clr = wr_en & (paddr == OFS_FAULT_CTRL) & pwdata[0];
    assign apply_cmd = wr_en & (paddr == OFS_APPLY) & pwdata[0];

    // address decode and read mux
    always_comb
    begin
        map_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_NODE_ADDR: rd_mux = {24'h000000, node_address_setting_r};
            OFS_BIT_RATE: rd_mux = {28'h0000000, bit_rate_select_r};
            OFS_PARITY: rd_mux = {30'h00000000, parity_select_r};
            OFS_LOSS_CFG: rd_mux = {27'h0000000, loss_detect_enable_r, 2'h0, loss_stop_action_r};
            OFS_REPLY_DELAY: rd_mux = {24'h000000, reply_delay_time_r};
            OFS_TX_CTRL: rd_mux = {31'h00000000, tx_enable_control_r};
            OFS_LOSS_TIME: rd_mux = {25'h0000000, loss_detect_time_r};
            OFS_VMON_UNIT: rd_mux = {31'h00000000, voltage_monitor_unit_r};
            OFS_APPLY_SEL: rd_mux = {31'h00000000, apply_command_select_r};
            OFS_RUN_METHOD: rd_mux = {31'h00000000, run_method_select_r};
            OFS_SOURCES: rd_mux = {24'h000000, sources_r};
            OFS_RUN_CMD: rd_mux = {30'h00000000, run_cmd_r};
            OFS_FREQ_REF: rd_mux = {16'h0000, freq_link_r};
            OFS_MFI_LINK: rd_mux = 32'(mfi_link_r);
            OFS_PARAM: rd_mux = {param_stage_r, param_value};
            OFS_APPLY: rd_mux = 32'h0000_0000;
            OFS_FAULT_CTRL: rd_mux = 32'h0000_0000;
            OFS_STATUS: rd_mux = {8'h00, node_act_r, 2'h0, parity_act_r, rate_act_r, tick_cnt_r, comm_fault};
            OFS_VMON: rd_mux = {16'h0000, vmon_r};
            default:
            begin
                map_hit = 1'b0;
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // apb answer: ready in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= rd_setup;
            prdata <= (rd_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
            pslverr <= rd_setup & ~map_hit;
        end
    end

    // serial settings; out of range node address, bit rate, parity and loss time values are ignored, old value stays
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            node_address_setting_r <= NODE_ADDR_RST;
            bit_rate_select_r <= BIT_RATE_RST;
            parity_select_r <= PARITY_RST;
            loss_stop_action_r <= STOP_ACT_RST;
            loss_detect_enable_r <= LOSS_EN_RST;
            reply_delay_time_r <= 8'h00;
            tx_enable_control_r <= TX_CTRL_RST;
            loss_detect_time_r <= LOSS_TIME_RST;
            voltage_monitor_unit_r <= VMON_UNIT_RST;
            apply_command_select_r <= APPLY_SEL_RST;
            run_method_select_r <= RUN_METHOD_RST;
            sources_r <= 8'h00;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                OFS_NODE_ADDR:
                    if (pwdata[7:0] <= NODE_ADDR_MAX && pwdata[31:8] == 24'h0)
                        node_address_setting_r <= pwdata[7:0];
                OFS_BIT_RATE: if (pwdata[3:0] <= BIT_RATE_MAX && pwdata[31:4] == 28'h0) bit_rate_select_r <= pwdata[3:0];
                OFS_PARITY:
                    if (pwdata[1:0] <= PARITY_MAX && pwdata[31:2] == 30'h0)
                        parity_select_r <= pwdata[1:0];
                OFS_LOSS_CFG:
                begin
                    loss_stop_action_r <= pwdata[1:0];
                    loss_detect_enable_r <= pwdata[4];
                end
                OFS_REPLY_DELAY: reply_delay_time_r <= pwdata[7:0];
                OFS_TX_CTRL: tx_enable_control_r <= pwdata[0];
                // detection time up to 10.0 s
                OFS_LOSS_TIME:
                    if (pwdata[6:0] <= LOSS_TIME_MAX && pwdata[31:7] == 25'h0)
                        loss_detect_time_r <= pwdata[6:0];
                OFS_VMON_UNIT: voltage_monitor_unit_r <= pwdata[0];
                OFS_APPLY_SEL: apply_command_select_r <= pwdata[0];
                OFS_RUN_METHOD: run_method_select_r <= pwdata[0];
                OFS_SOURCES: sources_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_cmd_r <= 2'h0;
            freq_link_r <= 16'h0000;
            mfi_link_r <= '0;
            param_stage_r <= 16'h0000;
        end
        else if (wr_en)
        begin
            if (paddr == OFS_RUN_CMD) run_cmd_r <= pwdata[1:0];
            if (paddr == OFS_FREQ_REF) freq_link_r <= pwdata[15:0];
            if (paddr == OFS_MFI_LINK) mfi_link_r <= pwdata[MFI_W-1:0];
            if (paddr == OFS_PARAM) param_stage_r <= pwdata[15:0];
        end
    end

    // parameter commit path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            param_value <= 16'h0000;
        else if (apply_command_select_r && wr_en && paddr == OFS_PARAM)
            param_value <= pwdata[15:0];
        else if (!apply_command_select_r && apply_cmd)
            param_value <= param_stage_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            node_act_r <= NODE_ADDR_RST;
            rate_act_r <= BIT_RATE_RST;
            parity_act_r <= PARITY_RST;
        end
        else if (power_restart)
        begin
            node_act_r <= node_address_setting_r;
            rate_act_r <= bit_rate_select_r;
            parity_act_r <= parity_select_r;
        end
    end

    // line format outputs follow the live settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            baud_div <= 17'h00000;
            parity_mode <= PARITY_RST;
        end
        else
        begin
            baud_div <= rate_div(rate_act_r);
            parity_mode <= parity_act_r;
        end
    end

    // frame check: crc over all bytes including the check pair leaves zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crc_r <= CRC_INIT;
            frame_addr_r <= 8'h00;
            first_r <= 1'b1;
            byte_cnt_r <= 8'h00;
        end
        else if (rx_frame_end)
        begin
            crc_r <= CRC_INIT;
            first_r <= 1'b1;
            byte_cnt_r <= 8'h00;
        end
        else if (rx_valid)
        begin
            crc_r <= crc_byte(crc_r, rx_data);
            first_r <= 1'b0;
            if (first_r) frame_addr_r <= rx_data;
            if (byte_cnt_r != 8'hff) byte_cnt_r <= byte_cnt_r + 8'h01;
        end
    end

    // command accept; four bytes is the shortest frame with a check
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_valid <= 1'b0;
            cmd_broadcast <= 1'b0;
        end
        else
        begin
            cmd_valid <= rx_frame_end && crc_r == 16'h0000 && byte_cnt_r >= 8'h04
                && (frame_addr_r == node_act_r || frame_addr_r == 8'h00);
            cmd_broadcast <= rx_frame_end && crc_r == 16'h0000 && byte_cnt_r >= 8'h04 && frame_addr_r == 8'h00;
        end
    end

    // reply delay in whole milliseconds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reply_pend_r <= 1'b0;
            delay_ms_r <= 8'h00;
            delay_cyc_r <= 32'h0000_0000;
            reply_start <= 1'b0;
        end
        else
        begin
            reply_start <= 1'b0;
            if (cmd_valid && !cmd_broadcast && node_act_r != 8'h00)
            begin
                reply_pend_r <= 1'b1;
                delay_ms_r <= reply_delay_time_r;
                delay_cyc_r <= 32'h0000_0000;
            end
            else if (reply_pend_r)
            begin
                if (delay_ms_r == 8'h00)
                begin
                    reply_pend_r <= 1'b0;
                    reply_start <= 1'b1;
                end
                else if (delay_cyc_r == MS_CYC - 1)
                begin
                    delay_cyc_r <= 32'h0000_0000;
                    delay_ms_r <= delay_ms_r - 8'h01;
                end
                else
                    delay_cyc_r <= delay_cyc_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rts <= 1'b0;
        else
            rts <= !tx_enable_control_r || tx_busy;
    end

    // loss watchdog in 0.1 s ticks, saturating so it cannot wrap back
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cyc_r <= 32'h0000_0000;
            tick_cnt_r <= 7'h00;
        end
        else if (rx_valid || !loss_detect_enable_r)
        begin
            tick_cyc_r <= 32'h0000_0000;
            tick_cnt_r <= 7'h00;
        end
        else if (tick_cyc_r == TICK_CYC - 1)
        begin
            tick_cyc_r <= 32'h0000_0000;
            if (tick_cnt_r != 7'h7f) tick_cnt_r <= tick_cnt_r + 7'h01;
        end
        else
            tick_cyc_r <= tick_cyc_r + 32'h0000_0001;
    end

    assign loss_trip = loss_detect_enable_r && tick_cnt_r > loss_detect_time_r;

    // sticky fault; a trip in the clearing cycle keeps it set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            comm_fault <= 1'b0;
        else if (loss_trip)
            comm_fault <= 1'b1;
        else if (fault_clr)
            comm_fault <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_ramp <= 1'b0;
            stop_coast <= 1'b0;
            stop_fast <= 1'b0;
        end
        else
        begin
            stop_ramp <= comm_fault && mbscs_stop_t'(loss_stop_action_r) == MBSCS_STOP_RAMP;
            stop_coast <= comm_fault && mbscs_stop_t'(loss_stop_action_r) == MBSCS_STOP_COAST;
            stop_fast <= comm_fault && mbscs_stop_t'(loss_stop_action_r) == MBSCS_STOP_FAST;
        end
    end

    // source of the active external reference
    assign freq_src = ext_ref_sel ? sources_r[5:4] : sources_r[1:0];
    assign run_src = ext_ref_sel ? sources_r[7:6] : sources_r[3:2];
    assign link_ok = freq_src == SRC_SERIAL && run_src == SRC_SERIAL;

    // run and reference; a latched stop action forces run off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_fwd <= 1'b0;
            run_rev <= 1'b0;
            freq_ref <= 16'h0000;
        end
        else if (link_ok && !stop_ramp && !stop_coast && !stop_fast)
        begin
            freq_ref <= freq_link_r;
            if (!run_method_select_r)
            begin
                run_fwd <= run_cmd_r[0] && !run_cmd_r[1];
                run_rev <= run_cmd_r[1] && !run_cmd_r[0];
            end
            else
            begin
                run_fwd <= run_cmd_r[0] && !run_cmd_r[1];
                run_rev <= run_cmd_r[0] && run_cmd_r[1];
            end
        end
        else
        begin
            run_fwd <= 1'b0;
            run_rev <= 1'b0;
            freq_ref <= link_ok ? freq_link_r : 16'h0000;
        end
    end

    // monitor and inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vmon_r <= 16'h0000;
            mfi_eff <= '0;
        end
        else
        begin
            vmon_r <= voltage_monitor_unit_r ? (volt_raw / 16'd10) : volt_raw;
            mfi_eff <= mfi_term | mfi_link_r;
        end
    end

endmodule
`default_nettype wire
